// ==== src/rss_pkg.sv ====
/*
 * Shared constants and types of the reset strap sampler: strap pin order,
 * default levels, management port codes, register map and timing counts.
 * Assumes a 50 MHz core clock and a 32-bit APB register bus.
 */
package rss_pkg;

   // ==========================================================
   // Strap pins
   localparam int unsigned STRAP_W = 5;
   localparam int unsigned IDX_FLOW = 0;
   localparam int unsigned IDX_MGMT_LO = 1;
   localparam int unsigned IDX_MGMT_HI = 2;
   localparam int unsigned IDX_START = 3;
   localparam int unsigned IDX_INBAND = 4;
   // Default strap levels; the weak pulls point the same way.
   localparam logic [STRAP_W-1:0] STRAP_DEFAULT = 5'h0f;

   // ==========================================================
   // Captured configuration
   typedef struct packed {
      logic inband;
      logic start;
      logic mgmt_hi;
      logic mgmt_lo;
      logic flow;
   } rss_strap_type;

   typedef enum logic [1:0] {
      MGMT_SERIAL = 2'b00,
      MGMT_I2C = 2'b01,
      MGMT_SPI = 2'b10
   } rss_mgmt_type;

   typedef enum logic [1:0] {
      ST_HOLD = 2'b00,
      ST_SOFT = 2'b01,
      ST_RUN = 2'b10
   } rss_state_type;

   // ==========================================================
   // Register map
   localparam logic [11:0] ADDR_CTRL = 12'h000;
   localparam logic [11:0] ADDR_STATUS = 12'h004;
   localparam int unsigned CTRL_START_BIT = 0;
   localparam int unsigned CTRL_SOFT_BIT = 1;
   localparam int unsigned STAT_HIZ_BIT = 8;
   localparam int unsigned STAT_FWD_BIT = 9;
   localparam logic CTRL_START_RESET = 1'b0;

   // ==========================================================
   // Timing
   localparam int unsigned CLK_MHZ = 50;
   localparam int unsigned SOFT_HIZ_NS = 1000;
   localparam int unsigned SOFT_HIZ_CYC = (SOFT_HIZ_NS * CLK_MHZ + 999) / 1000;
   localparam logic [7:0] SOFT_HIZ_CNT = 8'(SOFT_HIZ_CYC);

endpackage : rss_pkg

// ==== src/rss_pin_cell.sv ====
/*
 * One strap-capable pin: weak pull toward its default, capture latch of
 * the pin level, and the pad driver for the pin's normal output function.
 * Assumes the parent sequences hi-Z and capture; the pad wire is resolved
 * outside from the output enable and the pulls.
 */
`timescale 1ns/1ps

module rss_pin_cell #(
   parameter logic DEFAULT_LEVEL = 1'b1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Sequencing from the parent
   input wire logic capture,
   input wire logic hiz,
   // Pad
   input wire logic pin_i,
   output logic pin_o,
   output logic pin_oe_n,
   output logic pull_up,
   output logic pull_dn,
   // Normal function and captured level
   input wire logic func,
   output logic value
);

   // ==========================================================
   // Capture latch
   // The level is taken only on a capture and held until the next one.
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         value <= DEFAULT_LEVEL;
      end
      else if (capture)
      begin
         value <= pin_i;
      end
   end

   // ==========================================================
   // Pad driver
   // Output data is registered; the enable follows hiz at once.
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         pin_o <= 1'b1;
      end
      else
      begin
         pin_o <= func;
      end
   end

   // The pin floats whenever a reset holds it, and drives otherwise.
   assign pin_oe_n = hiz;

   // The weak pull always points toward the default level.
   assign pull_up = DEFAULT_LEVEL;
   assign pull_dn = ~DEFAULT_LEVEL;

endmodule : rss_pin_cell

// ==== src/rss_top.sv ====
/*
 * Reset strap sampler top: follows the active-low system reset pin and a
 * software reset, floats the strap pins during reset, captures their
 * levels on release and hands out the derived mode settings. An APB
 * slave gives access to the start and soft reset controls and status.
 * Assumes all inputs synchronous to CLK and board pulls on the pads.
 */
// The address map and register access over APB were decided locally.
// Notes on behaviour
// - Strap pins float while system reset low.
// - Pin levels captured when system reset releases.
// - Weak pull toward default on each pin.
// - Pins drive normal outputs after reset release.
// - Software reset also captures the straps.
// - Management strap pair selects host port.
// - Start strap low waits for software start.
// - In-band strap high enables port management.
// - Flow strap high enables flow control.
`timescale 1ns/1ps

module rss_top (
   // Clock and reset
   input wire logic CLK,
   input wire logic SRST,
   // System reset pin, active low
   input wire logic SYS_RESET_N,
   // Strap pads
   input wire logic [rss_pkg::STRAP_W-1:0] PIN_I,
   output logic [rss_pkg::STRAP_W-1:0] PIN_O,
   output logic [rss_pkg::STRAP_W-1:0] PIN_OE_N,
   output logic [rss_pkg::STRAP_W-1:0] PIN_PU_EN,
   output logic [rss_pkg::STRAP_W-1:0] PIN_PD_EN,
   // Normal pin functions
   input wire logic [rss_pkg::STRAP_W-1:0] PIN_FUNC,
   // Mode settings
   output rss_pkg::rss_strap_type STRAP_CFG,
   output rss_pkg::rss_mgmt_type MGMT_PORT,
   output logic INBAND_EN,
   output logic FLOW_EN,
   output logic FWD_EN,
   // APB slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR
);

   localparam int SOFT_I = int'(rss_pkg::SOFT_HIZ_CYC);

   rss_pkg::rss_state_type state_r;
   rss_pkg::rss_state_type state_nxt;
   logic [7:0] soft_cnt_r;
   logic [rss_pkg::STRAP_W-1:0] cap_vec;
   logic capture;
   logic hiz;
   logic start_bit_r;
   logic fwd_r;
   logic wr_acc;
   logic soft_req;
   logic addr_ok;
   logic [31:0] rd_nxt;

   // ==========================================================
   // Reset sequencer
   // Next state: hold while the pin is low, soft window on request.
   always_comb
   begin
      state_nxt = state_r;
      unique case (state_r)
         rss_pkg::ST_HOLD:
         begin
            if (SYS_RESET_N)
            begin
               state_nxt = rss_pkg::ST_RUN;
            end
         end
         rss_pkg::ST_SOFT:
         begin
            if (!SYS_RESET_N)
            begin
               state_nxt = rss_pkg::ST_HOLD;
            end
            else if (soft_cnt_r == 8'h01)
            begin
               state_nxt = rss_pkg::ST_RUN;
            end
         end
         rss_pkg::ST_RUN:
         begin
            if (!SYS_RESET_N)
            begin
               state_nxt = rss_pkg::ST_HOLD;
            end
            else if (soft_req)
            begin
               state_nxt = rss_pkg::ST_SOFT;
            end
         end
         default:
         begin
            state_nxt = rss_pkg::ST_HOLD;
         end
      endcase
   end

   // State register.
   always_ff @(posedge CLK)
   begin
      if (SRST)
      begin
         state_r <= rss_pkg::ST_HOLD;
      end
      else
      begin
         state_r <= state_nxt;
      end
   end

   // Soft reset window counter, loaded on request and counted down.
   always_ff @(posedge CLK)
   begin
      if (SRST)
      begin
         soft_cnt_r <= 8'h00;
      end
      else if (state_r == rss_pkg::ST_RUN && soft_req)
      begin
         soft_cnt_r <= rss_pkg::SOFT_HIZ_CNT;
      end
      else if (soft_cnt_r != 8'h00)
      begin
         soft_cnt_r <= soft_cnt_r - 8'h01;
      end
   end

   // Capture on release of the pin reset or at the end of a soft window.
   assign capture = SYS_RESET_N &&
      ((state_r == rss_pkg::ST_HOLD) ||
       (state_r == rss_pkg::ST_SOFT && soft_cnt_r == 8'h01));

   // Pins float in any reset state and at once when the pin goes low.
   assign hiz = !SYS_RESET_N || (state_r != rss_pkg::ST_RUN);

   // ==========================================================
   // Strap pin cells
   genvar gi;
   generate
      for (gi = 0; gi < rss_pkg::STRAP_W; gi++)
      begin : g_pin
         rss_pin_cell #(
            .DEFAULT_LEVEL(rss_pkg::STRAP_DEFAULT[gi])
         ) u_cell (
            .clk(CLK),
            .srst(SRST),
            .capture(capture),
            .hiz(hiz),
            .pin_i(PIN_I[gi]),
            .pin_o(PIN_O[gi]),
            .pin_oe_n(PIN_OE_N[gi]),
            .pull_up(PIN_PU_EN[gi]),
            .pull_dn(PIN_PD_EN[gi]),
            .func(PIN_FUNC[gi]),
            .value(cap_vec[gi])
         );
      end
   endgenerate

   // ==========================================================
   // Mode decode
   // Captured levels feed the mode settings directly.
   assign STRAP_CFG = rss_pkg::rss_strap_type'(cap_vec);
   assign INBAND_EN = STRAP_CFG.inband;
   assign FLOW_EN = STRAP_CFG.flow;

   // High strap bit picks SPI whatever the low bit is.
   always_comb
   begin
      if (STRAP_CFG.mgmt_hi)
      begin
         MGMT_PORT = rss_pkg::MGMT_SPI;
      end
      else if (STRAP_CFG.mgmt_lo)
      begin
         MGMT_PORT = rss_pkg::MGMT_I2C;
      end
      else
      begin
         MGMT_PORT = rss_pkg::MGMT_SERIAL;
      end
   end

   // Software start bit; any reset returns it to its reset value.
   always_ff @(posedge CLK)
   begin
      if (SRST || hiz)
      begin
         start_bit_r <= rss_pkg::CTRL_START_RESET;
      end
      else if (wr_acc && PADDR == rss_pkg::ADDR_CTRL)
      begin
         start_bit_r <= PWDATA[rss_pkg::CTRL_START_BIT];
      end
   end

   // Forwarding runs out of reset if strapped, else after software start.
   always_ff @(posedge CLK)
   begin
      if (SRST)
      begin
         fwd_r <= 1'b0;
      end
      else
      begin
         fwd_r <= !hiz && (STRAP_CFG.start || start_bit_r);
      end
   end

   assign FWD_EN = fwd_r;

   // ==========================================================
   // APB slave
   // Zero wait states; unmapped addresses answer with an error.
   assign addr_ok = (PADDR == rss_pkg::ADDR_CTRL) ||
      (PADDR == rss_pkg::ADDR_STATUS);
   assign PREADY = 1'b1;
   assign PSLVERR = PSEL && PENABLE && !addr_ok;
   assign wr_acc = PSEL && PENABLE && PWRITE && addr_ok;
   assign soft_req = wr_acc && (PADDR == rss_pkg::ADDR_CTRL) &&
      PWDATA[rss_pkg::CTRL_SOFT_BIT];

   // Read data for the setup cycle address; soft reset bit reads zero.
   always_comb
   begin
      rd_nxt = 32'h0000_0000;
      if (PADDR == rss_pkg::ADDR_CTRL)
      begin
         rd_nxt[rss_pkg::CTRL_START_BIT] = start_bit_r;
      end
      else if (PADDR == rss_pkg::ADDR_STATUS)
      begin
         rd_nxt[rss_pkg::STRAP_W-1:0] = cap_vec;
         rd_nxt[rss_pkg::STAT_HIZ_BIT] = hiz;
         rd_nxt[rss_pkg::STAT_FWD_BIT] = fwd_r;
      end
   end

   // Read data is registered in the setup cycle.
   always_ff @(posedge CLK)
   begin
      if (SRST)
      begin
         PRDATA <= 32'h0000_0000;
      end
      else if (PSEL && !PENABLE && !PWRITE)
      begin
         PRDATA <= rd_nxt;
      end
   end

   // ==========================================================
   // Assertions
   default clocking cb @(posedge CLK); endclocking
   default disable iff (SRST);

   a_hiz_in_reset: assert property (
      !SYS_RESET_N |-> (PIN_OE_N == 5'h1f))
      else $error("Strap pins driven during system reset.");

   a_capture_edge: assert property (
      (state_r == rss_pkg::ST_HOLD) && SYS_RESET_N
      |=> (cap_vec == $past(PIN_I)))
      else $error("Strap levels not captured at reset release.");

   a_pull_default: assert property (
      (PIN_PU_EN == rss_pkg::STRAP_DEFAULT) &&
      ((PIN_PU_EN ^ PIN_PD_EN) == 5'h1f))
      else $error("Weak pull not toward default level.");

   a_drive_after: assert property (
      $rose(SYS_RESET_N) && (state_r == rss_pkg::ST_HOLD)
      |-> (PIN_OE_N == 5'h1f) ##1 (PIN_OE_N == 5'h00))
      else $error("Pins not driven after reset release.");

   a_soft_capture: assert property (
      soft_req && (state_r == rss_pkg::ST_RUN) && SYS_RESET_N
      |=> (PIN_OE_N == 5'h1f) ##[1:SOFT_I] (capture || !SYS_RESET_N))
      else $error("Software reset did not capture straps.");

   a_mgmt_decode: assert property (
      (STRAP_CFG.mgmt_hi |-> MGMT_PORT == rss_pkg::MGMT_SPI) and
      (!STRAP_CFG.mgmt_hi && STRAP_CFG.mgmt_lo
       |-> MGMT_PORT == rss_pkg::MGMT_I2C) and
      (!STRAP_CFG.mgmt_hi && !STRAP_CFG.mgmt_lo
       |-> MGMT_PORT == rss_pkg::MGMT_SERIAL))
      else $error("Management port decode wrong.");

   a_fwd_start: assert property (
      !hiz && !STRAP_CFG.start && !start_bit_r |=> !FWD_EN)
      else $error("Forwarding began without start.");

   a_inband_cap: assert property (
      capture |=> (INBAND_EN == $past(PIN_I[rss_pkg::IDX_INBAND])))
      else $error("In-band enable not from captured strap.");

   a_flow_cap: assert property (
      capture |=> (FLOW_EN == $past(PIN_I[rss_pkg::IDX_FLOW])))
      else $error("Flow control enable not from captured strap.");

   a_hold_stable: assert property (
      !capture |=> $stable(cap_vec))
      else $error("Captured straps changed outside a capture.");

endmodule : rss_top

// ==== tb/rss_board_model.sv ====
/*
 * Board model: strap resistors and weak pulls on the five strap pads.
 * Assumes the device pad outputs and a board strap level and fitted mask.
 */
`timescale 1ns/1ps

module rss_board_model (
   // Device pad side
   input wire logic [4:0] pin_o,
   input wire logic [4:0] pin_oe_n,
   input wire logic [4:0] pu_en,
   input wire logic [4:0] pd_en,
   // Board straps
   input wire logic [4:0] fitted,
   input wire logic [4:0] level,
   // Resolved pads
   output logic [4:0] pin_i
);
   // ==========================================================
   // Pad resolution
   // A driven pad wins, a fitted strap beats the weak pull, a bare pad flips.
   always_comb
   begin
      for (int i = 0; i < 5; i++)
      begin
         if (pin_oe_n[i] == 1'b0)
            pin_i[i] = pin_o[i];
         else if (fitted[i])
            pin_i[i] = level[i];
         else if (pu_en[i])
            pin_i[i] = 1'b1;
         else if (pd_en[i])
            pin_i[i] = 1'b0;
         else
            pin_i[i] = ~pin_o[i];
      end
   end
endmodule : rss_board_model

// ==== tb/test_reset_strap_sampler.sv ====
/*
 * Testbench of the strap sampler: resets, strap captures, start and
 * soft reset over APB. Assumes the board model resolves the pads.
 */
`timescale 1ns/1ps

module test_reset_strap_sampler;
   // ==========================================================
   // Signals
   logic CLK = 1'b0;
   logic SRST = 1'b1;
   logic SYS_RESET_N = 1'b0;
   logic [4:0] PIN_I, PIN_O, PIN_OE_N, PIN_PU_EN, PIN_PD_EN;
   logic [4:0] PIN_FUNC = 5'h15;
   logic [4:0] fitted = 5'h00;
   logic [4:0] level = 5'h00;
   rss_pkg::rss_strap_type STRAP_CFG;
   rss_pkg::rss_mgmt_type MGMT_PORT;
   logic INBAND_EN, FLOW_EN, FWD_EN, PREADY, PSLVERR;
   logic PSEL = 1'b0;
   logic PENABLE = 1'b0;
   logic PWRITE = 1'b0;
   logic [11:0] PADDR = 12'h000;
   logic [31:0] PWDATA = 32'h0, PRDATA, rd;
   logic er;
   int num_errors = 0;
   int samples_checked = 0;

   rss_top DUT (.CLK(CLK), .SRST(SRST), .SYS_RESET_N(SYS_RESET_N),
      .PIN_I(PIN_I), .PIN_O(PIN_O), .PIN_OE_N(PIN_OE_N),
      .PIN_PU_EN(PIN_PU_EN), .PIN_PD_EN(PIN_PD_EN), .PIN_FUNC(PIN_FUNC),
      .STRAP_CFG(STRAP_CFG), .MGMT_PORT(MGMT_PORT), .INBAND_EN(INBAND_EN),
      .FLOW_EN(FLOW_EN), .FWD_EN(FWD_EN), .PSEL(PSEL), .PENABLE(PENABLE),
      .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
      .PREADY(PREADY), .PSLVERR(PSLVERR));
   rss_board_model board (.pin_o(PIN_O), .pin_oe_n(PIN_OE_N),
      .pu_en(PIN_PU_EN), .pd_en(PIN_PD_EN), .fitted(fitted),
      .level(level), .pin_i(PIN_I));

   // Clock of 20 ns period.
   initial
   begin
      forever #10 CLK = ~CLK;
   end

   // ==========================================================
   // Tasks
   // Prints the counts and the verdict, then ends the run.
   task print_verdict;
      $display("checked %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : print_verdict

   // Compares one value and reports a mismatch.
   task check_vec(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e)
      begin
         num_errors++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask : check_vec

   // One APB transfer; waits for PREADY under a bound.
   task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge CLK);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLK);
      PENABLE <= 1'b1;
      do
      begin
         @(posedge CLK);
         n++;
      end while (PREADY !== 1'b1 && n < 20);
      rd = PRDATA;
      er = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      if (n >= 20)
      begin
         num_errors++;
         print_verdict();
      end
   endtask : apb

   // Checks pads driven from their functions and the mode outputs.
   task check_cfg(input logic [4:0] s);
      check_vec("oe_n", 32'h0, 32'(PIN_OE_N));
      check_vec("pin_o", 32'(PIN_FUNC), 32'(PIN_O));
      check_vec("pad", 32'(PIN_FUNC), 32'(PIN_I));
      check_vec("cfg", 32'(s), 32'(STRAP_CFG));
      check_vec("mgmt", s[2] ? 32'h2 : 32'(s[1]), 32'(MGMT_PORT));
      check_vec("inband", 32'(s[4]), 32'(INBAND_EN));
      check_vec("flow", 32'(s[0]), 32'(FLOW_EN));
   endtask : check_cfg

   // Pulses system reset with a board strap set and checks the capture.
   task hw_capture(input logic [4:0] f, input logic [4:0] l);
      logic [4:0] s;
      logic [4:0] pu;
      logic [4:0] pd;
      s = (l & f) | (rss_pkg::STRAP_DEFAULT & ~f);
      pu = rss_pkg::STRAP_DEFAULT;
      pd = ~pu;
      @(posedge CLK);
      SYS_RESET_N <= 1'b0;
      fitted <= f;
      level <= l;
      repeat (4) @(posedge CLK);
      #1 check_vec("oe_n rst", 32'h1f, 32'(PIN_OE_N));
      check_vec("pull up", 32'(pu), 32'(PIN_PU_EN));
      check_vec("pull dn", 32'(pd), 32'(PIN_PD_EN));
      @(posedge CLK);
      SYS_RESET_N <= 1'b1;
      repeat (3) @(posedge CLK);
      #1 check_cfg(s);
      check_vec("fwd", 32'(s[3]), 32'(FWD_EN));
   endtask : hw_capture

   // Straps change after capture; start bit written; status read.
   task hold_and_start;
      @(posedge CLK);
      level <= 5'h1f;
      PIN_FUNC <= 5'h0a;
      repeat (10) @(posedge CLK);
      check_vec("held", 32'h0, 32'(STRAP_CFG));
      check_vec("pin_o run", 32'h0a, 32'(PIN_O));
      check_vec("pad run", 32'h0a, 32'(PIN_I));
      apb(rss_pkg::ADDR_CTRL, 1'b1, 32'h1);
      repeat (3) @(posedge CLK);
      check_vec("fwd start", 32'h1, 32'(FWD_EN));
      apb(rss_pkg::ADDR_STATUS, 1'b0, 32'h0);
      check_vec("status", 32'h200, rd);
      apb(12'h010, 1'b0, 32'h0);
      check_vec("err", 32'h1, 32'(er));
      check_vec("err data", 32'h0, rd);
   endtask : hold_and_start

   // Soft reset floats the pads and captures the new straps.
   task soft_capture;
      apb(rss_pkg::ADDR_CTRL, 1'b1, 32'h2);
      repeat (2) @(posedge CLK);
      #1 check_vec("oe_n soft", 32'h1f, 32'(PIN_OE_N));
      repeat (55) @(posedge CLK);
      #1 check_cfg(5'h1f);
      check_vec("fwd soft", 32'h1, 32'(FWD_EN));
   endtask : soft_capture

   // ==========================================================
   // Main sequence
   initial
   begin
      repeat (16) @(posedge CLK);
      SRST <= 1'b0;
      hw_capture(5'h00, 5'h00);
      hw_capture(5'h1f, 5'h1f);
      hw_capture(5'h1f, 5'h05);
      hw_capture(5'h1f, 5'h0a);
      hw_capture(5'h1f, 5'h00);
      hold_and_start();
      soft_capture();
      print_verdict();
   end
endmodule : test_reset_strap_sampler
